// ==== design/instruction_class_privilege_decode.sv ====
// instruction classification, privilege gating and long-latency sequencing
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module instruction_class_privilege_decode (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded class toward the pipeline
  output decode_pkg::class_s dec_class,
  output logic dec_valid,
  output logic long_busy,
  // interrupt
  output logic irq
);
  import decode_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] instr;
  logic [7:0] ctrl;
  logic [31:0] opnd_hi;
  logic [31:0] opnd_lo;
  logic [31:0] result;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_enable;
  logic issue;
  long_state_e long_state;
  logic [3:0] long_cnt;

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  wire [1:0] f_op = instr[OP_HI:OP_LO];
  wire [4:0] f_rd = instr[RD_HI:RD_LO];
  wire [5:0] f_op3 = instr[OP3_HI:OP3_LO];
  wire [4:0] f_rs1 = instr[RS1_HI:RS1_LO];
  wire [7:0] f_asi = instr[ASI_HI:ASI_LO];
  wire [8:0] f_opf = instr[OPF_HI:OPF_LO];
  wire [2:0] f_op2 = instr[OP2_HI:OP2_LO];
  wire priv_mode = ctrl[CTRL_PRIV];
  wire [2:0] align_off = ctrl[CTRL_ALIGN_HI:CTRL_ALIGN_LO];

  wire is_arith = (f_op == OP_ARITH);
  wire is_mem = (f_op == OP_MEM);
  wire is_fpop = is_arith && (f_op3 == OP3_FPOP1 || f_op3 == OP3_FPOP2);

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  wire d_population_count_op = is_arith && (f_op3 == OP3_POPULATION_COUNT_OP);
  wire d_sqrt = is_fpop && (f_opf == OPF_FSQRTS || f_opf == OPF_FSQRTD);
  wire d_div = is_fpop && (f_opf == OPF_FDIVS || f_opf == OPF_FDIVD);
  wire d_long = d_sqrt || d_div;
  wire d_dbl = f_opf[1];
  // quad encodings share the opf low two bits 11 for arith, compare and move
  wire d_quad = is_fpop && (f_opf[1:0] == OPF_QUAD);
  wire d_signalling_float_compare_op = is_fpop && (f_opf == OPF_FCMPES || f_opf == OPF_FCMPED);
  wire d_falign = is_arith && f_op3 == OP3_IMPDEP1 && f_opf == OPF_FALIGN;
  wire d_pref = is_mem && (f_op3 == OP3_PREFETCH || f_op3 == OP3_PREFETCHA);
  wire d_atomic_byte_load_store_op = is_mem && (f_op3 == OP3_ATOMIC_BYTE_LOAD_STORE_OP);
  wire d_set_high_immediate_op = (f_op == OP_FMT2) && (f_op2 == OP2_SET_HIGH_IMMEDIATE_OP);
  wire d_cmov = is_arith && (f_op3 == OP3_MOVCC) || is_arith && f_op3 == OP3_FPOP2
    && f_opf[5:4] == 2'h0 && f_opf[3:0] != 4'h0 && !d_signalling_float_compare_op;
  wire asi_blk = f_asi == ASI_BLK0 || f_asi == ASI_BLK1 || f_asi == ASI_BLK2
    || f_asi == ASI_BLK3 || f_asi == ASI_BLK4 || f_asi == ASI_BLK5
    || f_asi == ASI_BLK6 || f_asi == ASI_BLK7 || f_asi == ASI_BLK8
    || f_asi == ASI_BLK9;
  wire asi_short = f_asi[7:4] == ASI_SHORT_HI && f_asi[2:0] <= ASI_SHORT_LAST;
  wire asi_part = f_asi[7:4] == ASI_PART_HI && f_asi[2:0] <= ASI_PART_LAST;
  wire d_blk_ld = is_mem && f_op3 == OP3_FLOAT_ALTERNATE_SPACE_LOAD_OP && asi_blk;
  wire d_blk_st = is_mem && f_op3 == OP3_FLOAT_ALTERNATE_SPACE_STORE_OP && asi_blk;
  wire d_short = is_mem && f_op3 == OP3_FLOAT_ALTERNATE_SPACE_STORE_OP && asi_short;
  wire d_part = is_mem && f_op3 == OP3_FLOAT_ALTERNATE_SPACE_STORE_OP && asi_part;

  // ----------------------------------------------------------------
  // privilege checks
  // ----------------------------------------------------------------
  wire rd_asr = is_arith && f_op3 == OP3_RDASR;
  wire wr_asr = is_arith && f_op3 == OP3_WRASR;
  wire pic_acc = (rd_asr && f_rs1 == ASR_PIC) || (wr_asr && f_rd == ASR_PIC);
  wire g_pic = pic_acc && ctrl[CTRL_PERF_CONTROL_PRIVILEGE_BIT];
  wire g_rtick = rd_asr && ((f_rs1 == ASR_TICK && !ctrl[CTRL_TICK_NPT])
    || (f_rs1 == ASR_SYSTEM_TICK_COUNTER && !ctrl[CTRL_SYSTEM_TICK_COUNTER_NPT]));
  wire g_wstick = wr_asr && f_rd == ASR_SYSTEM_TICK_COUNTER && !ctrl[CTRL_SYSTEM_TICK_COUNTER_NPT];
  wire g_prpr = is_arith && (f_op3 == OP3_PRIVILEGED_REGISTER_READ_OP || f_op3 == OP3_PRIVILEGED_REGISTER_WRITE_OP
    || (rd_asr && f_rs1 == ASR_PCR) || (wr_asr && f_rd == ASR_PCR));
  wire d_priv = !priv_mode && (g_pic || g_rtick || g_wstick || g_prpr);

  // a privilege fault masks every other class so nothing downstream acts
  wire kill = d_priv || d_population_count_op || d_quad;
  class_s next_class;
  always_comb begin
    next_class = '0;
    next_class.illegal = d_population_count_op;
    next_class.priv_fault = d_priv;
    next_class.quad_trap = d_quad && !d_priv;
    next_class.long_op = d_long && !kill;
    next_class.prefetch = d_pref && !kill;
    next_class.prefetch_fcn = d_pref ? f_rd : 5'h00;
    next_class.block_load = d_blk_ld && !kill;
    next_class.block_store = d_blk_st && !kill;
    next_class.short_store = d_short && !kill;
    next_class.partial_store = d_part && !kill;
    next_class.atomic_byte = d_atomic_byte_load_store_op && !kill;
    next_class.set_high = d_set_high_immediate_op && !kill;
    next_class.sig_compare = d_signalling_float_compare_op && !kill;
    next_class.data_align = d_falign && !kill;
    next_class.cond_move = d_cmov && !kill;
    if ((d_blk_ld || d_blk_st) && !kill) begin
      next_class.xfer_bytes = BLOCK_BYTES;
    end else if (d_pref && !kill) begin
      next_class.xfer_bytes = PREFETCH_BYTES;
    end
  end

  // ----------------------------------------------------------------
  // data results
  // ----------------------------------------------------------------
  wire [127:0] pair = {opnd_hi, opnd_lo, opnd_hi, opnd_lo};
  wire [6:0] shift_bits = {1'b0, align_off, 3'h0};
  wire [63:0] pair64 = {opnd_hi, opnd_lo};
  wire [127:0] shifted = pair << shift_bits;
  wire [31:0] align_res = shifted[127:96];
  wire [31:0] set_high_immediate_op_res = {instr[IMM22_HI:IMM22_LO], 10'h000};
  // unordered is flagged by software as opnd_lo bit 0 (nan compare outcome)
  wire unord = opnd_lo[0];
  wire [1:0] fcc = unord ? 2'h3 : (pair64 == 64'h0 ? 2'h0 : 2'h1);
  // conditional move: the test source is either integer or float codes
  wire cmov_take = ctrl[CTRL_ICC_SEL] ? opnd_hi[0] : (fcc != 2'h0);
  // atomic byte: old byte returned, memory byte set all ones in one access
  wire [31:0] atomic_byte_load_store_op_res = {24'h000000, opnd_lo[7:0]};

  logic [31:0] next_result;
  always_comb begin
    next_result = result;
    if (issue && !kill) begin
      if (d_set_high_immediate_op) begin
        next_result = set_high_immediate_op_res;
      end else if (d_falign) begin
        next_result = align_res;
      end else if (d_signalling_float_compare_op) begin
        next_result = {30'h00000000, fcc};
      end else if (d_atomic_byte_load_store_op) begin
        next_result = atomic_byte_load_store_op_res;
      end else if (d_cmov) begin
        next_result = cmov_take ? opnd_lo : opnd_hi;
      end
    end
  end

  // ----------------------------------------------------------------
  // long-latency sequencer
  // ----------------------------------------------------------------
  wire [3:0] lat = d_sqrt ? (d_dbl ? SQRT_LAT_D : SQRT_LAT_S)
    : (d_dbl ? DIV_LAT_D : DIV_LAT_S);
  long_state_e next_long_state;
  logic [3:0] next_long_cnt;
  always_comb begin
    next_long_state = long_state;
    next_long_cnt = long_cnt;
    case (long_state)
      LONG_IDLE: begin
        if (issue && d_long && !kill) begin
          next_long_state = LONG_RUN;
          next_long_cnt = lat;
        end
      end
      LONG_RUN: begin
        next_long_cnt = long_cnt - 4'h1;
        if (long_cnt == 4'h1) begin
          next_long_state = LONG_DONE;
        end
      end
      default: begin
        next_long_state = LONG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  wire [EV_W-1:0] ev;
  assign ev[EV_ILLEGAL] = issue && d_population_count_op;
  assign ev[EV_PRIV] = issue && d_priv;
  assign ev[EV_QUAD] = issue && d_quad && !d_priv;
  assign ev[EV_UNORD] = issue && d_signalling_float_compare_op && !kill && unord;
  assign ev[EV_LONG_DONE] = long_state == LONG_DONE;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_instr = do_write && aw_addr == ADDR_INSTR;
  wire wr_ctrl = do_write && aw_addr == ADDR_CTRL;
  wire wr_en = do_write && aw_addr == ADDR_IRQ_ENABLE;
  wire wr_clr = do_write && aw_addr == ADDR_IRQ_CLEAR;
  wire wr_hi = do_write && aw_addr == ADDR_OPND_HI;
  wire wr_lo = do_write && aw_addr == ADDR_OPND_LO;
  wire wr_ro = do_write && (aw_addr == ADDR_CLASS || aw_addr == ADDR_RESULT
    || aw_addr == ADDR_IRQ_STATUS || aw_addr == ADDR_BUSY);
  wire wr_ok = wr_instr || wr_ctrl || wr_en || wr_clr || wr_hi || wr_lo || wr_ro;
  // a new instruction is refused while a long operation is in flight
  wire accept_instr = wr_instr && long_state == LONG_IDLE;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    merge = {st[3] ? nw[31:24] : old[31:24], st[2] ? nw[23:16] : old[23:16],
             st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  wire [31:0] w_merged_instr = merge(instr, w_data, w_strb);
  wire [31:0] w_merged_ctrl = merge({24'h000000, ctrl}, w_data, w_strb);
  wire [31:0] w_merged_hi = merge(opnd_hi, w_data, w_strb);
  wire [31:0] w_merged_lo = merge(opnd_lo, w_data, w_strb);

  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_val =
    ra == ADDR_INSTR ? instr :
    ra == ADDR_CTRL ? {24'h000000, ctrl} :
    ra == ADDR_CLASS ? {5'h00, dec_class} :
    ra == ADDR_RESULT ? result :
    ra == ADDR_IRQ_STATUS ? {27'h0000000, irq_status} :
    ra == ADDR_IRQ_ENABLE ? {27'h0000000, irq_enable} :
    ra == ADDR_OPND_HI ? opnd_hi :
    ra == ADDR_OPND_LO ? opnd_lo :
    ra == ADDR_BUSY ? {31'h00000000, long_busy} : 32'h00000000;
  wire rd_ok = ra == ADDR_INSTR || ra == ADDR_CTRL || ra == ADDR_CLASS
    || ra == ADDR_RESULT || ra == ADDR_IRQ_STATUS || ra == ADDR_IRQ_ENABLE
    || ra == ADDR_OPND_HI || ra == ADDR_OPND_LO || ra == ADDR_BUSY
    || ra == ADDR_IRQ_CLEAR;

  // set wins over a clear landing in the same cycle
  wire [EV_W-1:0] clr_mask = wr_clr ? w_data[EV_W-1:0] : '0;
  wire [EV_W-1:0] next_status = (irq_status & ~clr_mask) | ev;

  // ----------------------------------------------------------------
  // sequential logic
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok && (!wr_instr || accept_instr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      instr <= 32'h00000000;
      ctrl <= CTRL_RESET;
      opnd_hi <= 32'h00000000;
      opnd_lo <= 32'h00000000;
      irq_enable <= '0;
      issue <= 1'b0;
    end else begin
      if (accept_instr) instr <= w_merged_instr;
      if (wr_ctrl) ctrl <= w_merged_ctrl[7:0];
      if (wr_hi) opnd_hi <= w_merged_hi;
      if (wr_lo) opnd_lo <= w_merged_lo;
      if (wr_en) irq_enable <= w_data[EV_W-1:0];
      issue <= accept_instr;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dec_class <= '0;
      dec_valid <= 1'b0;
      result <= 32'h00000000;
      irq_status <= '0;
      irq <= 1'b0;
      long_state <= LONG_IDLE;
      long_cnt <= 4'h0;
      long_busy <= 1'b0;
    end else begin
      dec_valid <= issue;
      if (issue) dec_class <= next_class;
      result <= next_result;
      irq_status <= next_status;
      irq <= |(next_status & irq_enable);
      long_state <= next_long_state;
      long_cnt <= next_long_cnt;
      long_busy <= next_long_state != LONG_IDLE;
    end
  end

endmodule

// ==== design/decode_pkg.sv ====
// shared constants and types for the instruction class and privilege decoder
package decode_pkg;

  // instruction major format and field positions
  localparam int OP_HI = 31;
  localparam int OP_LO = 30;
  localparam int RD_HI = 29;
  localparam int RD_LO = 25;
  localparam int OP3_HI = 24;
  localparam int OP3_LO = 19;
  localparam int RS1_HI = 18;
  localparam int RS1_LO = 14;
  localparam int IBIT = 13;
  localparam int ASI_HI = 12;
  localparam int ASI_LO = 5;
  localparam int OPF_HI = 13;
  localparam int OPF_LO = 5;
  localparam int IMM22_HI = 21;
  localparam int IMM22_LO = 0;
  localparam int OP2_HI = 24;
  localparam int OP2_LO = 22;

  localparam logic [1:0] OP_FMT2 = 2'h0;
  localparam logic [1:0] OP_ARITH = 2'h2;
  localparam logic [1:0] OP_MEM = 2'h3;
  localparam logic [2:0] OP2_SET_HIGH_IMMEDIATE_OP = 3'h4;

  // arithmetic-format op3 codes
  localparam logic [5:0] OP3_POPULATION_COUNT_OP = 6'h2E;
  localparam logic [5:0] OP3_RDASR = 6'h28;
  localparam logic [5:0] OP3_WRASR = 6'h30;
  localparam logic [5:0] OP3_PRIVILEGED_REGISTER_READ_OP = 6'h2A;
  localparam logic [5:0] OP3_PRIVILEGED_REGISTER_WRITE_OP = 6'h32;
  localparam logic [5:0] OP3_FPOP1 = 6'h34;
  localparam logic [5:0] OP3_FPOP2 = 6'h35;
  localparam logic [5:0] OP3_IMPDEP1 = 6'h36;
  localparam logic [5:0] OP3_MOVCC = 6'h2C;
  // memory-format op3 codes
  localparam logic [5:0] OP3_ATOMIC_BYTE_LOAD_STORE_OP = 6'h0D;
  localparam logic [5:0] OP3_FLOAT_ALTERNATE_SPACE_LOAD_OP = 6'h33;
  localparam logic [5:0] OP3_FLOAT_ALTERNATE_SPACE_STORE_OP = 6'h37;
  localparam logic [5:0] OP3_PREFETCH = 6'h2D;
  localparam logic [5:0] OP3_PREFETCHA = 6'h3D;

  // ancillary register numbers held in rs1/rd
  localparam logic [4:0] ASR_PCR = 5'h10;
  localparam logic [4:0] ASR_PIC = 5'h11;
  localparam logic [4:0] ASR_TICK = 5'h04;
  localparam logic [4:0] ASR_SYSTEM_TICK_COUNTER = 5'h18;

  // fpop and impdep1 opf codes
  localparam logic [8:0] OPF_FSQRTS = 9'h029;
  localparam logic [8:0] OPF_FSQRTD = 9'h02A;
  localparam logic [8:0] OPF_FDIVS = 9'h04D;
  localparam logic [8:0] OPF_FDIVD = 9'h04E;
  localparam logic [8:0] OPF_FCMPES = 9'h055;
  localparam logic [8:0] OPF_FCMPED = 9'h056;
  localparam logic [8:0] OPF_FALIGN = 9'h048;
  localparam logic [1:0] OPF_QUAD = 2'h3;

  // block load/store, short store and partial store asi identifiers
  localparam logic [7:0] ASI_BLK0 = 8'h70;
  localparam logic [7:0] ASI_BLK1 = 8'h71;
  localparam logic [7:0] ASI_BLK2 = 8'h78;
  localparam logic [7:0] ASI_BLK3 = 8'h79;
  localparam logic [7:0] ASI_BLK4 = 8'hF0;
  localparam logic [7:0] ASI_BLK5 = 8'hF1;
  localparam logic [7:0] ASI_BLK6 = 8'hF8;
  localparam logic [7:0] ASI_BLK7 = 8'hF9;
  localparam logic [7:0] ASI_BLK8 = 8'hE0;
  localparam logic [7:0] ASI_BLK9 = 8'hE1;
  localparam logic [3:0] ASI_SHORT_HI = 4'hD;
  localparam logic [3:0] ASI_PART_HI = 4'hC;
  localparam logic [2:0] ASI_SHORT_LAST = 3'h3;
  localparam logic [2:0] ASI_PART_LAST = 3'h5;

  // sizes and latencies
  localparam logic [7:0] BLOCK_BYTES = 8'h40;
  localparam logic [7:0] PREFETCH_BYTES = 8'h40;
  localparam logic [3:0] SQRT_LAT_S = 4'hC;
  localparam logic [3:0] SQRT_LAT_D = 4'hF;
  localparam logic [3:0] DIV_LAT_S = 4'hA;
  localparam logic [3:0] DIV_LAT_D = 4'hD;

  // axi register map
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CLASS = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_OPND_HI = 8'h1C;
  localparam logic [7:0] ADDR_OPND_LO = 8'h20;
  localparam logic [7:0] ADDR_BUSY = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ctrl bits
  localparam int CTRL_PRIV = 0;
  localparam int CTRL_PERF_CONTROL_PRIVILEGE_BIT = 1;
  localparam int CTRL_TICK_NPT = 2;
  localparam int CTRL_SYSTEM_TICK_COUNTER_NPT = 3;
  localparam int CTRL_ALIGN_LO = 4;
  localparam int CTRL_ALIGN_HI = 6;
  localparam int CTRL_ICC_SEL = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // event bits
  localparam int EV_ILLEGAL = 0;
  localparam int EV_PRIV = 1;
  localparam int EV_QUAD = 2;
  localparam int EV_UNORD = 3;
  localparam int EV_LONG_DONE = 4;
  localparam int EV_W = 5;

  typedef enum logic [1:0] {
    LONG_IDLE = 2'b00,
    LONG_RUN = 2'b01,
    LONG_DONE = 2'b10
  } long_state_e;

  // decoded class of one instruction
  typedef struct packed {
    logic illegal;
    logic priv_fault;
    logic quad_trap;
    logic long_op;
    logic prefetch;
    logic block_load;
    logic block_store;
    logic short_store;
    logic partial_store;
    logic atomic_byte;
    logic set_high;
    logic sig_compare;
    logic data_align;
    logic cond_move;
    logic [4:0] prefetch_fcn;
    logic [7:0] xfer_bytes;
  } class_s;

endpackage

// ==== test/decode_monitor.sv ====
// checker for the decoder top ports
`timescale 1ns/1ps
module decode_check
  import decode_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_arready,
  // decode side
  input wire decode_pkg::class_s dec_class,
  input wire logic dec_valid,
  input wire logic long_busy
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_busy_run;
    long_busy [*8];
  endsequence
  property p_valid_pulse;
    dec_valid |=> !dec_valid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_after_b;
    $rose(dec_valid) |-> $past(s_axi_bvalid);
  endproperty
  property p_long;
    dec_valid && dec_class.long_op |-> s_busy_run ##[1:20] !long_busy;
  endproperty
  property p_priv;
    dec_valid && dec_class.priv_fault |-> !(dec_class.prefetch || dec_class.block_store
      || dec_class.short_store || dec_class.partial_store || dec_class.long_op);
  endproperty
  property p_pref;
    dec_valid && dec_class.prefetch |-> dec_class.xfer_bytes >= 8'h40;
  endproperty
  property p_block;
    dec_valid && (dec_class.block_load || dec_class.block_store) |-> dec_class.xfer_bytes == 8'h40;
  endproperty
  property p_quad;
    dec_valid && dec_class.quad_trap |-> !dec_class.long_op && !long_busy;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("issue pulse too long");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_block: assert property (p_r_block) else $error("read taken while answer pending");
  a_after_b: assert property (p_after_b) else $error("issue without write");
  a_long: assert property (p_long) else $error("long op busy wrong");
  a_priv: assert property (p_priv) else $error("fault with side effect");
  a_pref: assert property (p_pref) else $error("prefetch too short");
  a_block: assert property (p_block) else $error("block size wrong");
  a_quad: assert property (p_quad) else $error("quad op executed");
endmodule

bind instruction_class_privilege_decode decode_check i_decode_check (.clk_sys, .nrst,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_arready,
  .dec_class, .dec_valid, .long_busy);

// ==== test/pipe_sink.sv ====
// behavioural pipeline slot that takes each issued class
`timescale 1ns/1ps
module pipe_sink
  import decode_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // from the decoder
  input wire decode_pkg::class_s dec_class,
  input wire logic dec_valid,
  // to the bench
  output logic taken,
  output decode_pkg::class_s taken_class
);
  // outside a pulse the slot shows the inverted class, so a stale class never matches
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      taken <= 1'b0;
      taken_class <= '0;
    end else begin
      taken <= dec_valid;
      taken_class <= dec_valid ? dec_class : ~dec_class;
    end
  end
endmodule

// ==== test/instruction_class_privilege_decode_tb_top.sv ====
// self-checking bench for the decoder
`timescale 1ns/1ps
module instruction_class_privilege_decode_tb_top;
  import decode_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hB083, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  class_s dec_class, taken_class;
  logic dec_valid, long_busy, irq, taken;
  int fail_count = 0, n_checks = 0;
  logic [26:0] exp_q [$];
  always #5 clk_sys = ~clk_sys;
  instruction_class_privilege_decode i_instruction_class_privilege_decode (.*);
  pipe_sink i_pipe_sink (.*);
  // ----
  // tasks
  // ----
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // answer is accepted one edge late so the slave must hold it
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  task automatic issue(input logic [31:0] i, input logic [26:0] e);
    exp_q.push_back(e);
    wr(ADDR_INSTR, i);
    chk("instr resp", RESP_OKAY, rs);
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 40 && long_busy; k++) @(posedge clk_sys);
  endtask
  // xfer size sits in the low 8 bits and is masked off, fcn is compared; size is left to the checker
  always @(posedge clk_sys) begin
    if (taken === 1'b1) begin
      if (exp_q.size() == 0) chk("extra issue", 0, 1);
      else chk("class", exp_q.pop_front(), taken_class & 27'h7FFFF00);
    end
  end
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    seed = xs(seed);
    wr(ADDR_OPND_LO, seed);
    rdr(ADDR_OPND_LO);
    chk("operand", seed, rd);
    rdr(8'hFC);
    chk("unmapped", RESP_SLVERR, rs);
    issue(32'h81700000, 27'h4000000);
    issue(32'h81500000, 27'h2000000);
    issue(32'h81A00560, 27'h1000000);
    issue(32'h81A00520, 27'h0800000);
    issue(32'hC1B80E00, 27'h0100000);
    issue(32'hC7680000, 27'h0400300);
    issue(32'hC1B81A00, 27'h0080000);
    issue(32'hC1B81A80, 27'h0000000);
    issue(32'hC1B818A0, 27'h0040000);
    wr(ADDR_OPND_HI, seed);
    wr(ADDR_OPND_LO, 32'h1);
    issue(32'hC1980E00, 27'h0200000);
    issue(32'hC0680000, 27'h0020000);
    rdr(ADDR_RESULT);
    chk("old byte", 32'h1, rd);
    issue(32'h0102AAAA, 27'h0010000);
    rdr(ADDR_RESULT);
    chk("set high", 32'h0AAAA800, rd);
    issue(32'h81B00900, 27'h0004000);
    rdr(ADDR_RESULT);
    chk("aligned", seed, rd);
    issue(32'h81A80AA0, 27'h0008000);
    rdr(ADDR_RESULT);
    chk("fcc", 32'h3, rd);
    issue(32'h81AA2020, 27'h0002000);
    wr(ADDR_CTRL, 32'h2);
    issue(32'h83444000, 27'h2000000);
    issue(32'h83460000, 27'h2000000);
    issue(32'hB1800000, 27'h2000000);
    wr(ADDR_CTRL, 32'h8);
    issue(32'h83444000, 27'h0000000);
    issue(32'h83460000, 27'h0000000);
    issue(32'hB1800000, 27'h0000000);
    wr(ADDR_CTRL, 32'h1);
    issue(32'h81500000, 27'h0000000);
    chk("irq masked", 0, irq);
    rdr(ADDR_IRQ_STATUS);
    chk("status", 32'h1F, rd);
    wr(ADDR_IRQ_ENABLE, 32'h1F);
    repeat (3) @(posedge clk_sys);
    chk("irq", 1, irq);
    wr(ADDR_IRQ_CLEAR, 32'h1F);
    repeat (3) @(posedge clk_sys);
    chk("irq cleared", 0, irq);
    chk("pending", 0, exp_q.size());
    print_verdict;
  end
endmodule
